// ---- hdl/amp_fault_supervisor.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "amp_fault_consts.svh"

module amp_fault_supervisor #(
   parameter int unsigned OVERLOAD_CYC = `OVERLOAD_CYC
) (
   input  wire logic                   clk,
   input  wire logic                   nrst,
   // ahb-lite slave
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic [31:0]                 hrdata,
   output logic                        hresp,
   // analog indications and pins
   input  wire amp_fault_pkg::sense_t  sense,
   input  wire logic [1:0]             overcurrent,
   input  wire logic                   sync_clock_io,
   input  wire logic                   pwm_frame,
   input  wire logic                   restart_n,
   // outputs
   output logic                        fault_n,
   output logic                        thermal_warn_clip_flag_n,
   output logic [3:0]                  half_bridge_hiz,
   output logic [1:0]                  pwm_run,
   output logic [1:0]                  bridge_flip,
   output logic                        irq
);
   import amp_fault_pkg::*;

   // ================================================================
   // synchronisers
   sense_t     sense_s;
   logic [1:0] oc_s;
   logic       sync_clk_s;
   logic       restart_s;
   logic       restart_d;
   logic       sync_clk_d;

   sync_bank #(
      .N ($bits(sense_t) + 4)
   ) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .d    ({sense, overcurrent, sync_clock_io, restart_n}),
      .q    ({sense_s, oc_s, sync_clk_s, restart_s})
   );

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         restart_d  <= 1'b0;
         sync_clk_d <= 1'b0;
      end else begin
         restart_d  <= restart_s;
         sync_clk_d <= sync_clk_s;
      end
   end

   wire restart_rise = restart_s & ~restart_d;

   // ================================================================
   // register state
   ctrl_t                  ctrl;
   logic [`IRQ_WIDTH-1:0]  irq_status;
   logic [`IRQ_WIDTH-1:0]  irq_mask;
   sup_state_t             state;
   sup_state_t             next_state;
   logic                   sync_lost;

   // ================================================================
   // sync clock activity
   logic [9:0] sync_cnt;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync_cnt  <= 10'h0;
         sync_lost <= 1'b0;
      end else if (!ctrl.slave_mode || (sync_clk_s != sync_clk_d)) begin
         sync_cnt  <= 10'h0;
         sync_lost <= 1'b0;
      end else if (sync_cnt >= 10'(`SYNC_LOSS_CYC - 1)) begin
         sync_lost <= 1'b1;
      end else begin
         sync_cnt <= sync_cnt + 10'h1;
      end
   end

   // ================================================================
   // per channel current limit and overload
   logic [1:0] limiting;
   logic [1:0] flip;
   logic [1:0] overload;

   genvar c;
   generate
      for (c = 0; c < `NUM_CHANNELS; c++) begin : g_chan
         chan_current_limit #(
            .OVERLOAD_CYC (OVERLOAD_CYC)
         ) u_cl (
            .clk         (clk),
            .nrst        (nrst),
            .pwm_frame   (pwm_frame),
            .overcurrent (oc_s[c]),
            .clear       (~restart_s),
            .limiting    (limiting[c]),
            .flip        (flip[c]),
            .overload    (overload[c])
         );
      end
   endgenerate

   // ================================================================
   // supervisor state machine
   logic [6:0] start_cnt;

   always_comb begin
      next_state = state;
      case (state)
         ST_POR:
            if (sense_s.por_ok)
               next_state = ST_OFF;
         ST_OFF:
            if (restart_rise)
               next_state = ST_START;
         ST_START:
            if (start_cnt >= 7'(`STARTUP_CYC - 1))
               next_state = ST_RUN;
         ST_RUN:
            if (sense_s.thermal_shutdown)
               next_state = ST_LATCH;
         ST_LATCH:
            next_state = ST_LATCH;
         default:
            next_state = ST_POR;
      endcase
      if (!sense_s.por_ok)
         next_state = ST_POR;
      else if (!restart_s && state != ST_POR)
         next_state = ST_OFF;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         state <= ST_POR;
      else
         state <= next_state;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         start_cnt <= 7'h0;
      else if (state == ST_START)
         start_cnt <= start_cnt + 7'h1;
      else
         start_cnt <= 7'h0;
   end

   // ================================================================
   // outputs
   logic       undervolt;
   logic       overvolt;
   logic       global_off;
   logic [1:0] chan_off;
   logic       next_fault;

   always_comb begin
      undervolt  = sense_s.analog_uv | sense_s.power_uv;
      overvolt   = sense_s.power_ov;
      global_off = (state != ST_RUN) | undervolt
                 | overvolt | sync_lost;
      if (ctrl.parallel_bridge_mode)
         chan_off = {2{|overload}};
      else
         chan_off = overload;
      if (state == ST_POR)
         next_fault = 1'b1;
      else if (!restart_s)
         next_fault = 1'b0;
      else
         next_fault = undervolt | overvolt | (state == ST_LATCH)
                    | (|overload);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fault_n                  <= 1'b0;
         thermal_warn_clip_flag_n <= 1'b1;
         half_bridge_hiz          <= 4'hf;
         pwm_run                  <= 2'h0;
         bridge_flip              <= 2'h0;
      end else begin
         fault_n                  <= ~next_fault;
         thermal_warn_clip_flag_n <= ~(sense_s.thermal_warning
                                       | sense_s.clip);
         for (int i = 0; i < `NUM_CHANNELS; i++) begin
            half_bridge_hiz[2*i]   <= global_off | chan_off[i];
            half_bridge_hiz[2*i+1] <= global_off | chan_off[i];
            pwm_run[i]             <= ~(global_off | chan_off[i]);
            bridge_flip[i]         <= flip[i] & ~global_off;
         end
      end
   end

   // ================================================================
   // interrupt events
   logic                  fault_d;
   logic                  warn_d;
   logic                  clip_d;
   logic [`IRQ_WIDTH-1:0] events;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fault_d <= 1'b0;
         warn_d  <= 1'b0;
         clip_d  <= 1'b0;
      end else begin
         fault_d <= next_fault;
         warn_d  <= sense_s.thermal_warning;
         clip_d  <= sense_s.clip;
      end
   end

   always_comb begin
      events                     = '0;
      events[`IRQ_FAULT]         = next_fault & ~fault_d;
      events[`IRQ_THERMAL_WARN]  = sense_s.thermal_warning & ~warn_d;
      events[`IRQ_CLIP]          = sense_s.clip & ~clip_d;
      events[`IRQ_CURRENT_LIMIT] = |limiting;
      events[`IRQ_OVERLOAD]      = |overload;
      events[`IRQ_SYNC_LOSS]     = sync_lost;
   end

   // ================================================================
   // ahb-lite slave
   logic       wr_pend;
   logic [7:0] wr_addr;

   function automatic logic [7:0] word_addr(input logic [31:0] a);
      return {a[7:2], 2'b00};
   endfunction

   wire take = hsel & htrans[1] & hready;
   wire wr_ctrl = wr_pend && (wr_addr == `REG_CTRL);
   wire wr_irqs = wr_pend && (wr_addr == `REG_IRQ_STATUS);
   wire wr_mask = wr_pend && (wr_addr == `REG_IRQ_MASK);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h0;
      end else begin
         wr_pend <= take & hwrite;
         wr_addr <= word_addr(haddr);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl.slave_mode           <= 1'(`CTRL_RESET_VALUE >> `CTRL_SLAVE_MODE);
         ctrl.parallel_bridge_mode <= 1'(`CTRL_RESET_VALUE >> `CTRL_PARALLEL);
      end else if (wr_ctrl) begin
         ctrl.slave_mode           <= hwdata[`CTRL_SLAVE_MODE];
         ctrl.parallel_bridge_mode <= hwdata[`CTRL_PARALLEL];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         irq_mask <= '0;
      else if (wr_mask)
         irq_mask <= hwdata[`IRQ_WIDTH-1:0];
   end

   // new events win over a write-one-to-clear in the same cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         irq_status <= '0;
      else if (wr_irqs)
         irq_status <= (irq_status & ~hwdata[`IRQ_WIDTH-1:0]) | events;
      else
         irq_status <= irq_status | events;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         irq <= 1'b0;
      else
         irq <= |(irq_status & irq_mask);
   end

   logic [31:0] rd_word;

   always_comb begin
      rd_word = 32'h0;
      case (word_addr(haddr))
         `REG_CTRL: begin
            rd_word[`CTRL_SLAVE_MODE] = ctrl.slave_mode;
            rd_word[`CTRL_PARALLEL]   = ctrl.parallel_bridge_mode;
         end
         `REG_STATUS: begin
            rd_word[`ST_STATE_LSB +: 3]    = state;
            rd_word[`ST_LATCH_BIT]         = (state == ST_LATCH);
            rd_word[`ST_OVERLOAD_LSB +: 2] = overload;
            rd_word[`ST_LIMIT_LSB +: 2]    = limiting;
            rd_word[`ST_SYNC_LOST_BIT]     = sync_lost;
            rd_word[`ST_UNDERVOLT_BIT]     = undervolt;
            rd_word[`ST_OVERVOLT_BIT]      = overvolt;
            rd_word[`ST_FAULT_BIT]         = ~fault_n;
         end
         `REG_IRQ_STATUS:
            rd_word[`IRQ_WIDTH-1:0] = irq_status;
         `REG_IRQ_MASK:
            rd_word[`IRQ_WIDTH-1:0] = irq_mask;
         default:
            rd_word = 32'h0;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hrdata    <= 32'h0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (take && !hwrite)
            hrdata <= rd_word;
      end
   end

endmodule

`default_nettype wire

// ---- hdl/amp_fault_consts.svh ----
// Function
// - hold outputs off and fault during power-up
// - analog undervoltage: bridges off, fault low
// - undervoltage recovery is automatic, no reset
// - overvoltage: bridges off, fault while over
// - global fault stops all channels, fault low
// - latched global fault cleared only by reset
// - channel fault stops only the affected channel, both channels in parallel bridge mode
// - reset low forces fault output high, except in the power-up state
// - current limit flips bridge at fs/3, silent
// - lost sync clock: bridges off, no fault
// - reset rising edge starts startup, then switching
// - flag held low while output approaches clipping
// - thermal shutdown latches; warning only self-clears
// - persistent overcurrent latches channel off, fault
`ifndef AMP_FAULT_CONSTS_SVH
`define AMP_FAULT_CONSTS_SVH

// ===================================================================
// register map
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define REG_IRQ_STATUS     8'h08
`define REG_IRQ_MASK       8'h0c

// ctrl fields
`define CTRL_SLAVE_MODE    0
`define CTRL_PARALLEL      1
`define CTRL_RESET_VALUE   32'h0000_0000

// irq fields
`define IRQ_FAULT          0
`define IRQ_THERMAL_WARN   1
`define IRQ_CLIP           2
`define IRQ_CURRENT_LIMIT  3
`define IRQ_OVERLOAD       4
`define IRQ_SYNC_LOSS      5
`define IRQ_WIDTH          6

// status fields
`define ST_STATE_LSB       0
`define ST_LATCH_BIT       4
`define ST_OVERLOAD_LSB    5
`define ST_LIMIT_LSB       7
`define ST_SYNC_LOST_BIT   9
`define ST_UNDERVOLT_BIT   10
`define ST_OVERVOLT_BIT    11
`define ST_FAULT_BIT       12

// ===================================================================
// timing
`define CLK_PERIOD_NS      10
`define STARTUP_NS         1000
`define STARTUP_CYC        ((`STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OVERLOAD_US        1700
`define OVERLOAD_CYC       ((`OVERLOAD_US * 1000) / `CLK_PERIOD_NS)
`define SYNC_MIN_PERIOD_NS 10000
`define SYNC_LOSS_CYC      (`SYNC_MIN_PERIOD_NS / `CLK_PERIOD_NS)
`define LIMIT_FLIP_FRAMES  2'h2
`define NUM_CHANNELS       2
`define NUM_HALF_BRIDGES   4

`endif

// ---- hdl/amp_fault_pkg.sv ----
package amp_fault_pkg;

   // analog comparator and sensor indications, all active high
   typedef struct packed {
      logic por_ok;
      logic analog_uv;
      logic power_uv;
      logic power_ov;
      logic thermal_warning;
      logic thermal_shutdown;
      logic clip;
   } sense_t;

   typedef struct packed {
      logic slave_mode;
      logic parallel_bridge_mode;
   } ctrl_t;

   typedef enum logic [2:0] {
      ST_POR   = 3'b000,
      ST_OFF   = 3'b001,
      ST_START = 3'b010,
      ST_RUN   = 3'b011,
      ST_LATCH = 3'b100
   } sup_state_t;

endpackage

// ---- hdl/sync_bank.sv ----
`timescale 1ns/100ps
`default_nettype none

module sync_bank #(
   parameter int N = 1
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [N-1:0] d,
   output logic      [N-1:0] q
);
   logic [N-1:0] meta;

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_bit
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               meta[i] <= 1'b0;
               q[i]    <= 1'b0;
            end else begin
               meta[i] <= d[i];
               q[i]    <= meta[i];
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// ---- hdl/chan_current_limit.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "amp_fault_consts.svh"

module chan_current_limit #(
   parameter int unsigned OVERLOAD_CYC = `OVERLOAD_CYC
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic pwm_frame,
   input  wire logic overcurrent,
   input  wire logic clear,
   output logic      limiting,
   output logic      flip,
   output logic      overload
);
   logic [1:0]  frame_cnt;
   logic [17:0] persist_cnt;

   assign limiting = overcurrent & ~overload;

   // state flip every third frame while limiting
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         frame_cnt <= 2'h0;
         flip      <= 1'b0;
      end else if (!limiting) begin
         frame_cnt <= 2'h0;
         flip      <= 1'b0;
      end else if (pwm_frame) begin
         if (frame_cnt == `LIMIT_FLIP_FRAMES) begin
            frame_cnt <= 2'h0;
            flip      <= ~flip;
         end else begin
            frame_cnt <= frame_cnt + 2'h1;
         end
      end
   end

   // overload once limiting persists
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         persist_cnt <= 18'h0;
         overload    <= 1'b0;
      end else if (clear) begin
         persist_cnt <= 18'h0;
         overload    <= 1'b0;
      end else if (!overcurrent) begin
         persist_cnt <= 18'h0;
      end else if (!overload) begin
         if (persist_cnt >= 18'(OVERLOAD_CYC - 1))
            overload <= 1'b1;
         else
            persist_cnt <= persist_cnt + 18'h1;
      end
   end

endmodule

`default_nettype wire

// ---- sim/amp_fault_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module amp_fault_checker (
   input wire logic                  clk,
   input wire logic                  nrst,
   input wire amp_fault_pkg::sense_t sense,
   input wire logic [1:0]            overcurrent,
   input wire logic                  restart_n,
   input wire logic                  fault_n,
   input wire logic                  thermal_warn_clip_flag_n,
   input wire logic [3:0]            half_bridge_hiz,
   input wire logic [1:0]            pwm_run,
   input wire logic [1:0]            bridge_flip
);
   import amp_fault_pkg::*;
   // ===========================================================
   // supervisor properties
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!nrst);
   sequence s_running;
      (pwm_run == 2'b11 && restart_n)[*4];
   endsequence
   sequence s_overheat;
      (sense.thermal_shutdown && restart_n)[*5];
   endsequence
   chk_por_off: assert property (
      (!sense.por_ok && restart_n)[*6] |-> !fault_n && half_bridge_hiz == 4'hf)
      else $error("outputs live before power-on");
   chk_uv_trip: assert property (
      (restart_n && (sense.analog_uv || sense.power_uv))[*6]
      |-> !fault_n && half_bridge_hiz == 4'hf)
      else $error("undervoltage left bridges driven");
   chk_ov_trip: assert property (
      (restart_n && sense.power_ov)[*6]
      |-> !fault_n && half_bridge_hiz == 4'hf && pwm_run == 2'b00)
      else $error("overvoltage left bridges driven");
   chk_reset_fault_high: assert property (
      (!restart_n && sense.por_ok)[*6] |-> fault_n)
      else $error("fault shown while restart held low");
   chk_flag_warns: assert property (
      (sense.thermal_warning || sense.clip)[*4] |-> !thermal_warn_clip_flag_n)
      else $error("flag idle during warning");
   chk_flag_clears: assert property (
      (!(sense.thermal_warning || sense.clip))[*4] |-> thermal_warn_clip_flag_n)
      else $error("flag stuck active");
   chk_thermal_latch: assert property (
      s_running ##1 s_overheat ##1 restart_n[*8]
      |-> !fault_n && half_bridge_hiz == 4'hf)
      else $error("thermal shutdown did not latch");
   chk_limit_idle: assert property (
      (overcurrent == 2'b00)[*5] |-> bridge_flip == 2'b00)
      else $error("bridge flipped without overcurrent");
endmodule
bind amp_fault_supervisor amp_fault_checker props (
   .clk                      (clk),
   .nrst                     (nrst),
   .sense                    (sense),
   .overcurrent              (overcurrent),
   .restart_n                (restart_n),
   .fault_n                  (fault_n),
   .thermal_warn_clip_flag_n (thermal_warn_clip_flag_n),
   .half_bridge_hiz          (half_bridge_hiz),
   .pwm_run                  (pwm_run),
   .bridge_flip              (bridge_flip)
);
`default_nettype wire

// ---- sim/amp_controller_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module amp_controller_model #(
   parameter int HOLD_CYC = 400000,
   parameter int MIN_LOW  = 12
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic fault_n,
   input  wire logic flag_n,
   input  wire logic cycle_req,
   output logic      restart_n
);
   // ===========================================================
   // restart control of the system controller
   int   since_fall;
   int   low_cnt;
   logic fault_q;
   logic holding;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         restart_n <= 1'b0;
         holding <= 1'b1;
         since_fall <= 0;
         low_cnt <= 0;
         fault_q <= 1'b1;
      end else begin
         fault_q <= fault_n;
         if (fault_q && !fault_n) begin
            since_fall <= 0;
         end else if (since_fall < HOLD_CYC) begin
            since_fall <= since_fall + 1;
         end
         low_cnt <= restart_n ? 0 : low_cnt + 1;
         if (cycle_req) begin
            restart_n <= 1'b0;
            holding <= 1'b1;
         end else if (holding && low_cnt >= MIN_LOW && since_fall >= HOLD_CYC
                      && flag_n === 1'b1) begin
            restart_n <= 1'b1;
            holding <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ---- sim/amp_fault_supervisor_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "amp_fault_consts.svh"
module amp_fault_supervisor_test;
   import amp_fault_pkg::*;
   localparam int OVL = 60;
   logic        clk, nrst, hsel, hwrite, hready, hreadyout, hresp;
   logic        sync_clock_io, pwm_frame, restart_n, cycle_req, sync_run;
   logic        fault_n, flag_n, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, overcurrent, pwm_run, bridge_flip, fcnt;
   logic [2:0]  hsize;
   logic [3:0]  half_bridge_hiz;
   logic [9:0]  obs;
   sense_t      sense;
   int          failures, n_compared, n;
   assign hready = hreadyout;
   assign obs = {fault_n, flag_n, half_bridge_hiz, pwm_run, bridge_flip};
   amp_fault_supervisor #(.OVERLOAD_CYC(OVL)) dut (
      .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sense(sense),
      .overcurrent(overcurrent), .sync_clock_io(sync_clock_io),
      .pwm_frame(pwm_frame), .restart_n(restart_n), .fault_n(fault_n),
      .thermal_warn_clip_flag_n(flag_n), .half_bridge_hiz(half_bridge_hiz),
      .pwm_run(pwm_run), .bridge_flip(bridge_flip), .irq(irq));
   amp_controller_model #(.HOLD_CYC(30)) ctl (
      .clk(clk), .nrst(nrst), .fault_n(fault_n), .flag_n(flag_n),
      .cycle_req(cycle_req), .restart_n(restart_n));
   // ===========================================================
   // stimulus sources and tasks
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      fcnt <= fcnt + 2'd1;
      pwm_frame <= (fcnt == 2'd3);
      if (sync_run) sync_clock_io <= ~sync_clock_io;
   end
   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic cycles(input int c);
      repeat (c) @(posedge clk);
   endtask
   task automatic end_test(input string s);
      $display("test %0s done at %0t", s, $time);
   endtask
   // polls the outputs, bounded
   task automatic wait_obs(input logic [9:0] exp, input logic [9:0] m,
                           input int lim);
      int k;
      k = 0;
      n_compared++;
      while ((obs & m) !== exp && k < lim) begin
         @(posedge clk);
         k++;
      end
      if ((obs & m) !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h, expected %h", $time, obs & m, exp);
         final_report();
      end
   endtask
   task automatic bus_wait;
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hready !== 1'b1 && k < 50);
      if (hready !== 1'b1) begin
         failures++;
         $display("unexpected at %0t: got %h, expected %h", $time,
                  hready, 1'b1);
         final_report();
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      bus_wait();
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      bus_wait();
      rd = hrdata;
      check(hresp, 1'b0);
   endtask
   task automatic pulse_restart;
      cycle_req <= 1'b1;
      @(posedge clk);
      cycle_req <= 1'b0;
   endtask
   // ===========================================================
   // test sequence
   initial begin
      nrst = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'b010;
      sense = '0;
      overcurrent = 2'b00;
      {sync_clock_io, sync_run, pwm_frame, cycle_req, fcnt} = '0;
      failures = 0;
      n_compared = 0;
      cycles(6);
      nrst <= 1'b1;
      cycles(40);
      check(obs, 10'h1f0);
      ahb(1'b0, `REG_CTRL, 32'h0);
      check(rd, `CTRL_RESET_VALUE);
      ahb(1'b0, `REG_IRQ_MASK, 32'h0);
      check(rd, 32'h0);
      ahb(1'b1, `REG_CTRL, 32'h2);
      ahb(1'b0, `REG_CTRL, 32'h0);
      check(rd, 32'h2);
      ahb(1'b1, 32'h10, 32'hffff_ffff);
      ahb(1'b0, 32'h10, 32'h0);
      check(rd, 32'h0);
      ahb(1'b1, `REG_CTRL, 32'h0);
      ahb(1'b0, `REG_STATUS, 32'h0);
      check(rd[2:0], ST_POR);
      end_test("registers");
      sense.por_ok <= 1'b1;
      cycles(10);
      pulse_restart();
      cycles(8);
      check(obs, 10'h3f0);
      wait_obs(10'h30c, 10'h3ff, 300);
      end_test("startup");
      for (int i = 3; i <= 5; i++) begin
         sense[i] <= 1'b1;
         cycles(8);
         check(obs, 10'h1f0);
         sense[i] <= 1'b0;
         wait_obs(10'h30c, 10'h3ff, 300);
      end
      ahb(1'b0, `REG_IRQ_STATUS, 32'h0);
      check(rd[`IRQ_FAULT], 1'b1);
      check(irq, 1'b0);
      ahb(1'b1, `REG_IRQ_MASK, 32'h1);
      cycles(3);
      check(irq, 1'b1);
      ahb(1'b1, `REG_IRQ_STATUS, 32'h1);
      cycles(3);
      check(irq, 1'b0);
      end_test("supply faults");
      for (int i = 0; i <= 2; i += 2) begin
         sense[i] <= 1'b1;
         cycles(6);
         check(obs, 10'h20c);
         sense[i] <= 1'b0;
         cycles(6);
         check(obs, 10'h30c);
      end
      sense.thermal_warning <= 1'b1;
      sense.thermal_shutdown <= 1'b1;
      cycles(6);
      check(obs, 10'h0f0);
      sense.thermal_shutdown <= 1'b0;
      cycles(20);
      check(obs, 10'h0f0);
      pulse_restart();
      cycles(60);
      check(obs, 10'h2f0);
      sense.thermal_warning <= 1'b0;
      wait_obs(10'h30c, 10'h3ff, 300);
      end_test("thermal");
      overcurrent <= 2'b01;
      wait_obs(10'h30d, 10'h3ff, 40);
      n = 0;
      while (bridge_flip[0] === 1'b1 && n < 40) begin
         @(posedge clk);
         n += (pwm_frame === 1'b1) ? 1 : 0;
      end
      check(n, 3);
      wait_obs(10'h138, 10'h3fc, OVL + 40);
      overcurrent <= 2'b00;
      cycles(20);
      check(obs, 10'h138);
      pulse_restart();
      wait_obs(10'h30c, 10'h3ff, 300);
      end_test("overcurrent");
      ahb(1'b1, `REG_CTRL, 32'h2);
      overcurrent <= 2'b10;
      wait_obs(10'h1f0, 10'h3fc, OVL + 40);
      overcurrent <= 2'b00;
      pulse_restart();
      wait_obs(10'h30c, 10'h3ff, 300);
      end_test("parallel overload");
      sync_run <= 1'b1;
      ahb(1'b1, `REG_CTRL, 32'h1);
      cycles(20);
      check(obs, 10'h30c);
      sync_run <= 1'b0;
      wait_obs(10'h3f0, 10'h3f0, 1100);
      sync_run <= 1'b1;
      wait_obs(10'h30c, 10'h3ff, 300);
      end_test("sync loss");
      final_report();
   end
endmodule
`default_nettype wire
